// [design/host_port.sv]
// Parallel host port with byte-lane steering and two 64-byte queues.
// Assumes bus pins already synchronous to clk_sys; strobes last at least
// four clock cycles; the pad ring resolves data_out/data_oe_*.
//
// How it works
// - Two bus styles selectable, each with 8- or 16-bit data width.
// - One 64-byte queue per direction carries payload to and from CPU.
// - In 16-bit width, address bit zero and byte enable pick lanes.
// - Separate-strobe: word on both lanes, odd byte high, even low.
// - Direction-strobe: word on both lanes, odd byte low, even high.
// - Static latch pin picks demux style; toggling gives multiplexed, in separate-strobe style only.
// - Byte and word queue accesses may interleave freely.
// - Byte writes on either lane append to the queue in order.
// - Test data, mode and clock inputs carry pull-ups.
// - Scan logic resets itself at power-up; no test reset pin.
// - Each queue split in 32-byte halves; CPU sees only one.
`timescale 1ns/10ps
`include "host_port_regs.svh"
`default_nettype none

// ----------------------------------------------------------------------
// Generic FIFO
// ----------------------------------------------------------------------
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
  logic [LW-1:0] count_r, count_nxt;
  logic push, pop;

  assign in_ready = (count_r != LW'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem[rd_ptr_r];
  assign level = count_r;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wr_ptr_nxt = flush ? '0 : wr_ptr_r + AW'(push);
    rd_ptr_nxt = flush ? '0 : rd_ptr_r + AW'(pop);
    count_nxt = flush ? '0 : count_r + LW'(push) - LW'(pop);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // Storage needs no reset; count guards every read
  always_ff @(posedge clk_sys) begin
    if (push & !flush) begin
      mem[wr_ptr_r] <= in_data;
    end
  end
endmodule

// ----------------------------------------------------------------------
// Host port top
// ----------------------------------------------------------------------
module host_bus_byte_lane_port (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Straps
  input wire logic interface_type_select,
  input wire logic bus_width_select,
  // Host bus pins
  input wire logic cs_n,
  input wire logic rd_ds_n,
  input wire logic wr_rw,
  input wire logic ale,
  input wire logic high_byte_enable_n,
  input wire logic low_byte_enable_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe_lo,
  output logic data_oe_hi,
  // Register port toward the device core
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic [1:0] reg_be,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Line side of the transmit queue
  output logic [7:0] tx_line_data,
  output logic tx_line_valid,
  input wire logic tx_line_ready,
  // Line side of the receive queue
  input wire logic [7:0] rx_line_data,
  input wire logic rx_line_valid,
  output logic rx_line_ready,
  // Test access
  output logic scan_reset,
  output logic [2:0] test_pullup_en
);
  import host_port_pkg::*;

  // --------------------------------------------------------------------
  // Strap capture and bus style
  // --------------------------------------------------------------------
  logic cfg_done_r, cfg_done_nxt, dir_style_r, dir_style_nxt;
  logic wide_r, wide_nxt, ale_q_r, ale_q_nxt, mux_r, mux_nxt;
  logic [7:0] alat_r, alat_nxt;
  logic mux_mode, be_n, rd_act, wr_act, lane_even, lane_odd;
  logic [7:0] eff_addr;
  logic [15:0] data_int;

  always_comb begin
    cfg_done_nxt = 1'b1;
    // Straps caught once, after reset release
    dir_style_nxt = cfg_done_r ? dir_style_r : interface_type_select;
    wide_nxt = cfg_done_r ? wide_r : bus_width_select;
    ale_q_nxt = ale;
    // Any latch-pin edge means a multiplexed bus
    mux_nxt = mux_r | (cfg_done_r & (ale != ale_q_r));
    alat_nxt = ale ? data_in[7:0] : alat_r;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_done_r <= 1'b0;
      dir_style_r <= 1'b0;
      wide_r <= 1'b0;
      ale_q_r <= 1'b0;
      mux_r <= 1'b0;
      alat_r <= 8'h00;
    end else begin
      cfg_done_r <= cfg_done_nxt;
      dir_style_r <= dir_style_nxt;
      wide_r <= wide_nxt;
      ale_q_r <= ale_q_nxt;
      mux_r <= mux_nxt;
      alat_r <= alat_nxt;
    end
  end

  always_comb begin
    // Multiplexing exists only in the separate-strobe style
    mux_mode = mux_r & !dir_style_r;
    eff_addr = mux_mode ? alat_r : addr;
    be_n = dir_style_r ? low_byte_enable_n : high_byte_enable_n;
    rd_act = !cs_n & !rd_ds_n & (dir_style_r ? wr_rw : 1'b1);
    wr_act = !cs_n & (dir_style_r ? (!rd_ds_n & !wr_rw) : !wr_rw);
    if (!wide_r) begin
      // Narrow bus: one byte chosen by address bit zero alone
      lane_even = !eff_addr[0];
      lane_odd = eff_addr[0];
    end else begin
      lane_even = !eff_addr[0];
      lane_odd = !be_n;
      if (be_n & eff_addr[0]) begin
        lane_even = 1'b0;
        lane_odd = 1'b0;
      end
    end
    // Internal order: even byte low, odd byte high
    if (!wide_r) begin
      data_int = {2{data_in[7:0]}};
    end else if (dir_style_r) begin
      data_int = {data_in[7:0], data_in[15:8]};
    end else begin
      data_int = data_in;
    end
  end

  // --------------------------------------------------------------------
  // Queues
  // --------------------------------------------------------------------
  logic tx_push_req, tx_push, tx_in_ready, tx_ok;
  logic rx_pop_req, rx_pop, rx_out_valid, rx_ok, flush;
  logic stage_valid, stage_ready;
  logic [7:0] tx_byte, rx_head, stage_data, rx_byte;
  logic [6:0] rx_level;
  logic [5:0] tx_win_r, tx_win_nxt, rx_win_r, rx_win_nxt;

  stream_fifo #(.WIDTH(8), .DEPTH(`QUEUE_DEPTH)) transmit_queue (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .flush(flush),
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .in_data(tx_byte),
    .out_valid(tx_line_valid),
    .out_ready(tx_line_ready),
    .out_data(tx_line_data),
    .level()
  );

  // Small staging buffer decouples the line from the receive queue
  stream_fifo #(.WIDTH(8), .DEPTH(`STAGE_DEPTH)) rx_stage (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .flush(1'b0),
    .in_valid(rx_line_valid),
    .in_ready(rx_line_ready),
    .in_data(rx_line_data),
    .out_valid(stage_valid),
    .out_ready(stage_ready),
    .out_data(stage_data),
    .level()
  );

  stream_fifo #(.WIDTH(8), .DEPTH(`QUEUE_DEPTH)) receive_queue (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .flush(flush),
    .in_valid(stage_valid),
    .in_ready(stage_ready),
    .in_data(stage_data),
    .out_valid(rx_out_valid),
    .out_ready(rx_pop),
    .out_data(rx_head),
    .level(rx_level)
  );

  // --------------------------------------------------------------------
  // Access sequencer
  // --------------------------------------------------------------------
  port_state_t state_r, state_nxt;
  logic [7:0] cap_addr_r, cap_addr_nxt;
  logic cap_even_r, cap_even_nxt, cap_odd_r, cap_odd_nxt;
  logic [15:0] cap_data_r, cap_data_nxt, rdbuf_r, rdbuf_nxt, stat_word;
  logic is_queue, is_ctrl, is_stat, ctrl_wr, rel_tx, rel_rx;

  always_comb begin
    is_queue = ((cap_addr_r & `QUEUE_ADDR_MASK) == `QUEUE_ADDR);
    is_ctrl = (cap_addr_r == `CTRL_ADDR);
    is_stat = ((cap_addr_r & `QUEUE_ADDR_MASK) == `STAT_ADDR);
    // CPU sees only one half of each queue at a time
    tx_ok = tx_in_ready & (tx_win_r != `HALF_DEPTH);
    rx_ok = rx_out_valid & (rx_win_r != `HALF_DEPTH);
    rx_byte = rx_ok ? rx_head : 8'h00;
    stat_word = `STAT_RESET_VAL;
    stat_word[`STAT_DIR_STYLE_BIT] = dir_style_r;
    stat_word[`STAT_MUX_BIT] = mux_mode;
    stat_word[`STAT_WIDE_BIT] = wide_r;
    stat_word[`STAT_TX_WIN_FULL_BIT] = (tx_win_r == `HALF_DEPTH);
    stat_word[`STAT_RX_WIN_DONE_BIT] = (rx_win_r == `HALF_DEPTH);
    stat_word[`STAT_RX_LEVEL_LSB +: 7] = rx_level;
  end

  always_comb begin
    state_nxt = state_r;
    cap_addr_nxt = cap_addr_r;
    cap_even_nxt = cap_even_r;
    cap_odd_nxt = cap_odd_r;
    cap_data_nxt = cap_data_r;
    rdbuf_nxt = rdbuf_r;
    tx_push_req = 1'b0;
    tx_byte = cap_data_r[7:0];
    rx_pop_req = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ctrl_wr = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        cap_addr_nxt = eff_addr;
        cap_even_nxt = lane_even;
        cap_odd_nxt = lane_odd;
        cap_data_nxt = data_int;
        rdbuf_nxt = 16'h0000;
        if (wr_act) begin
          state_nxt = ST_WRITE;
        end else if (rd_act) begin
          state_nxt = ST_RD1;
        end
      end
      ST_WRITE: begin
        // Data is taken at the end of the strobe, when it is settled
        if (wr_act) begin
          cap_data_nxt = data_int;
        end else begin
          state_nxt = ST_IDLE;
          if (is_queue) begin
            // Even lane first, then odd: byte order is kept
            tx_push_req = cap_even_r | cap_odd_r;
            tx_byte = cap_even_r ? cap_data_r[7:0] : cap_data_r[15:8];
            if (cap_even_r & cap_odd_r) begin
              state_nxt = ST_WR2;
            end
          end else if (is_ctrl) begin
            ctrl_wr = cap_even_r;
          end else if (!is_stat) begin
            reg_wr = cap_even_r | cap_odd_r;
          end
        end
      end
      ST_WR2: begin
        tx_push_req = 1'b1;
        tx_byte = cap_data_r[15:8];
        state_nxt = ST_IDLE;
      end
      ST_RD1: begin
        state_nxt = ST_HOLD;
        if (is_queue) begin
          rx_pop_req = cap_even_r | cap_odd_r;
          if (cap_even_r) begin
            rdbuf_nxt[7:0] = rx_byte;
          end else begin
            rdbuf_nxt[15:8] = rx_byte;
          end
          if (cap_even_r & cap_odd_r) begin
            state_nxt = ST_RD2;
          end
        end else if (is_stat) begin
          rdbuf_nxt = stat_word;
        end else if (!is_ctrl) begin
          reg_rd = cap_even_r | cap_odd_r;
          state_nxt = ST_RD2;
        end
      end
      ST_RD2: begin
        state_nxt = ST_HOLD;
        if (is_queue) begin
          rx_pop_req = 1'b1;
          rdbuf_nxt[15:8] = rx_byte;
        end else begin
          rdbuf_nxt = reg_rdata;
        end
      end
      ST_HOLD: begin
        if (!rd_act) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_comb begin
    tx_push = tx_push_req & tx_ok;
    rx_pop = rx_pop_req & rx_ok;
    flush = ctrl_wr & cap_data_r[`CTRL_FLUSH_BIT];
    rel_tx = ctrl_wr & cap_data_r[`CTRL_TX_RELEASE_BIT];
    rel_rx = ctrl_wr & cap_data_r[`CTRL_RX_RELEASE_BIT];
    // Releasing a half reopens the window for the next one
    tx_win_nxt = (flush | rel_tx) ? 6'h00 : tx_win_r + 6'(tx_push);
    rx_win_nxt = (flush | rel_rx) ? 6'h00 : rx_win_r + 6'(rx_pop);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      cap_addr_r <= 8'h00;
      cap_even_r <= 1'b0;
      cap_odd_r <= 1'b0;
      cap_data_r <= 16'h0000;
      rdbuf_r <= 16'h0000;
      tx_win_r <= 6'h00;
      rx_win_r <= 6'h00;
    end else begin
      state_r <= state_nxt;
      cap_addr_r <= cap_addr_nxt;
      cap_even_r <= cap_even_nxt;
      cap_odd_r <= cap_odd_nxt;
      cap_data_r <= cap_data_nxt;
      rdbuf_r <= rdbuf_nxt;
      tx_win_r <= tx_win_nxt;
      rx_win_r <= rx_win_nxt;
    end
  end

  assign reg_addr = cap_addr_r;
  assign reg_wdata = cap_data_r;
  assign reg_be = {cap_odd_r, cap_even_r};

  // --------------------------------------------------------------------
  // Read data onto the pins
  // --------------------------------------------------------------------
  logic [15:0] data_out_r, data_out_nxt;
  logic oe_lo_r, oe_lo_nxt, oe_hi_r, oe_hi_nxt, drive;

  always_comb begin
    drive = (state_r == ST_HOLD) & rd_act;
    if (!wide_r) begin
      data_out_nxt = {8'h00, cap_odd_r ? rdbuf_r[15:8] : rdbuf_r[7:0]};
      oe_lo_nxt = drive & (cap_even_r | cap_odd_r);
      oe_hi_nxt = 1'b0;
    end else if (dir_style_r) begin
      data_out_nxt = {rdbuf_r[7:0], rdbuf_r[15:8]};
      oe_lo_nxt = drive & cap_odd_r;
      oe_hi_nxt = drive & cap_even_r;
    end else begin
      data_out_nxt = rdbuf_r;
      oe_lo_nxt = drive & cap_even_r;
      oe_hi_nxt = drive & cap_odd_r;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      data_out_r <= 16'h0000;
      oe_lo_r <= 1'b0;
      oe_hi_r <= 1'b0;
    end else begin
      data_out_r <= data_out_nxt;
      oe_lo_r <= oe_lo_nxt;
      oe_hi_r <= oe_hi_nxt;
    end
  end

  assign data_out = data_out_r;
  assign data_oe_lo = oe_lo_r;
  assign data_oe_hi = oe_hi_r;

  // --------------------------------------------------------------------
  // Test access support
  // --------------------------------------------------------------------
  logic [3:0] scan_cnt_r, scan_cnt_nxt;

  always_comb begin
    scan_cnt_nxt = (scan_cnt_r != 4'h0) ? scan_cnt_r - 4'h1 : 4'h0;
  end

  // Self reset of the scan logic, since no test reset pin exists
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scan_cnt_r <= 4'(`SCAN_RST_CYCLES);
    end else begin
      scan_cnt_r <= scan_cnt_nxt;
    end
  end

  assign scan_reset = (scan_cnt_r != 4'h0);
  // Pad pull-ups on test data, mode and clock inputs
  assign test_pullup_en = 3'b111;
endmodule

`default_nettype wire

// [design/host_port_pkg.sv]
// Types shared by the parallel host port.
// Assumes nothing beyond a SystemVerilog compiler.
package host_port_pkg;

  typedef enum {
    ST_IDLE,
    ST_WRITE,
    ST_WR2,
    ST_RD1,
    ST_RD2,
    ST_HOLD
  } port_state_t;

endpackage

// [design/host_port_regs.svh]
// Constants of the parallel host port: local register offsets, fields,
// queue sizes and timing counts.
// Assumes inclusion by bare name from the design file.
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH

// ----------------------------------------------------------------------
// Local register offsets
// ----------------------------------------------------------------------
`define QUEUE_ADDR 8'h00
`define QUEUE_ADDR_MASK 8'hfe
`define CTRL_ADDR 8'h02
`define STAT_ADDR 8'h04

// ----------------------------------------------------------------------
// Control fields (write-only pulses)
// ----------------------------------------------------------------------
`define CTRL_TX_RELEASE_BIT 0
`define CTRL_RX_RELEASE_BIT 1
`define CTRL_FLUSH_BIT 2

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define STAT_DIR_STYLE_BIT 0
`define STAT_MUX_BIT 1
`define STAT_WIDE_BIT 2
`define STAT_TX_WIN_FULL_BIT 3
`define STAT_RX_WIN_DONE_BIT 4
`define STAT_RX_LEVEL_LSB 8
`define STAT_RESET_VAL 16'h0000

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define QUEUE_DEPTH 64
`define HALF_DEPTH 6'h20
`define STAGE_DEPTH 4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define SCAN_RST_NS 64
`define SCAN_RST_CYCLES ((`SCAN_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [dv/core_side_model.sv]
// Device core stub behind the host port: register answers, a stalling
// transmit sink and a receive source of eight bytes after each reset.
// Assumes read data are wanted exactly the cycle after reg_rd.
`timescale 1ns/10ps
`default_nettype none
module core_side_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [1:0] reg_be,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Line sides
  input wire logic [7:0] tx_line_data,
  input wire logic tx_line_valid,
  output logic tx_line_ready,
  output logic [7:0] rx_line_data,
  output logic rx_line_valid,
  input wire logic rx_line_ready
);
  logic [7:0] tx_seen[$];
  logic [25:0] last_wr;
  logic [3:0] rx_cnt;
  assign rx_line_valid = rx_cnt < 4'h8;
  // Idle line shows changing junk, never the last byte
  assign rx_line_data = rx_line_valid ? 8'h50 + {4'h0, rx_cnt} :
    ~reg_rdata[7:0];
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
      tx_line_ready <= 1'b0;
      rx_cnt <= 4'h0;
      last_wr <= 26'h0;
      // Drained bytes are counted per reset
      tx_seen.delete();
    end else begin
      // Odd byte names the odd address; stale data inverted
      reg_rdata <= reg_rd ? {reg_addr | 8'h01, reg_addr & 8'hfe} : ~reg_rdata;
      // Half-rate ready keeps the drain side stalling
      tx_line_ready <= ~tx_line_ready;
      if (tx_line_valid && tx_line_ready) begin
        tx_seen.push_back(tx_line_data);
      end
      if (rx_line_valid && rx_line_ready) rx_cnt <= rx_cnt + 4'h1;
      if (reg_wr) last_wr <= {reg_addr, reg_be, reg_wdata};
    end
  end
endmodule
`default_nettype wire

// [dv/host_bus_byte_lane_port_test.sv]
// Bench of the host port: bus cycles in both styles, both widths and
// the multiplexed address phase, checked against lane rules.
// Assumes core_side_model on the core side and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module host_bus_byte_lane_port_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic interface_type_select = 1'b0;
  logic bus_width_select = 1'b1;
  logic cs_n = 1'b1;
  logic rd_ds_n = 1'b1;
  logic wr_rw = 1'b1;
  logic ale = 1'b0;
  logic high_byte_enable_n = 1'b1;
  logic low_byte_enable_n = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] data_in = 16'h0000;
  logic [15:0] data_out, reg_wdata, reg_rdata;
  logic [7:0] reg_addr, tx_line_data, rx_line_data;
  logic [1:0] reg_be;
  logic [2:0] test_pullup_en;
  logic data_oe_lo, data_oe_hi, reg_wr, reg_rd, tx_line_valid, tx_line_ready;
  logic rx_line_valid, rx_line_ready, scan_reset;
  logic mux = 1'b0;
  logic [17:0] got;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #4 clk_sys = ~clk_sys;
  host_bus_byte_lane_port host_bus_byte_lane_port_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst),
    .interface_type_select(interface_type_select),
    .bus_width_select(bus_width_select), .cs_n(cs_n), .rd_ds_n(rd_ds_n),
    .wr_rw(wr_rw), .ale(ale), .high_byte_enable_n(high_byte_enable_n),
    .low_byte_enable_n(low_byte_enable_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .data_oe_lo(data_oe_lo), .data_oe_hi(data_oe_hi),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_line_data(tx_line_data), .tx_line_valid(tx_line_valid),
    .tx_line_ready(tx_line_ready), .rx_line_data(rx_line_data),
    .rx_line_valid(rx_line_valid), .rx_line_ready(rx_line_ready),
    .scan_reset(scan_reset), .test_pullup_en(test_pullup_en));
  core_side_model core_side_model_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_line_data(tx_line_data),
    .tx_line_valid(tx_line_valid), .tx_line_ready(tx_line_ready),
    .rx_line_data(rx_line_data), .rx_line_valid(rx_line_valid),
    .rx_line_ready(rx_line_ready));
  task automatic end_sim();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [25:0] g, input logic [25:0] e);
    samples_checked++;
    if (g !== e) begin
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
      n_mismatch++;
    end
  endtask
  task automatic do_reset(input logic dir_style, input logic wide);
    sys_rst <= 1'b1;
    interface_type_select <= dir_style;
    bus_width_select <= wide;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  // One bus cycle; strobe held seven clocks, past the word minimum
  task automatic acc(input logic rd, input logic [7:0] a, input logic en_n,
                     input logic [15:0] d);
    if (mux) begin
      ale <= 1'b1;
      data_in <= {8'h00, a};
      repeat (2) @(posedge clk_sys);
      ale <= 1'b0;
      @(posedge clk_sys);
    end
    addr <= a;
    data_in <= d;
    high_byte_enable_n <= en_n;
    low_byte_enable_n <= en_n;
    cs_n <= 1'b0;
    rd_ds_n <= !(rd || interface_type_select);
    wr_rw <= rd;
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys);
    got = {data_oe_hi, data_oe_lo, data_oe_hi ? data_out[15:8] : 8'h00,
           data_oe_lo ? data_out[7:0] : 8'h00};
    @(posedge clk_sys);
    cs_n <= 1'b1;
    rd_ds_n <= 1'b1;
    wr_rw <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic rdx(input logic [7:0] a, input logic en_n,
                     input logic [17:0] e);
    acc(1'b1, a, en_n, 16'h0000);
    chk({8'h00, got}, {8'h00, e});
  endtask
  // Count of drained bytes, then up to the first four of them
  task automatic chk_tx(input int n, input logic [31:0] e);
    int i;
    for (i = 0; i < 400 && core_side_model_inst.tx_seen.size() < n; i++)
      @(posedge clk_sys);
    if (i == 400) begin
      n_mismatch++;
      end_sim();
    end
    repeat (20) @(posedge clk_sys);
    chk(26'(core_side_model_inst.tx_seen.size()), 26'(n));
    for (i = 0; i < n && i < 4; i++)
      chk(core_side_model_inst.tx_seen[i], e[31-8*i -: 8]);
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    end_sim();
  end
  initial begin
    do_reset(1'b0, 1'b1);
    acc(1'b0, 8'h00, 1'b0, 16'hb2a1);
    acc(1'b0, 8'h01, 1'b0, 16'hc300);
    acc(1'b0, 8'h00, 1'b1, 16'h00d4);
    chk_tx(4, 32'ha1b2c3d4);
    rdx(8'h00, 1'b0, {2'b11, 16'h5150});
    rdx(8'h01, 1'b0, {2'b10, 16'h5200});
    rdx(8'h00, 1'b1, {2'b01, 16'h0053});
    rdx(8'h11, 1'b1, 18'h00000);
    rdx(8'h10, 1'b0, {2'b11, 16'h1110});
    acc(1'b0, 8'h12, 1'b1, 16'h005a);
    chk(core_side_model_inst.last_wr & 26'h3ff00ff,
        {8'h12, 2'b01, 16'h005a});
    do_reset(1'b1, 1'b1);
    rdx(8'h04, 1'b1, {2'b10, 16'h0500});
    rdx(8'h10, 1'b0, {2'b11, 16'h1011});
    rdx(8'h11, 1'b0, {2'b01, 16'h0011});
    rdx(8'h11, 1'b1, 18'h00000);
    acc(1'b0, 8'h00, 1'b0, 16'h0e0f);
    chk_tx(2, 32'h0e0f0000);
    rdx(8'h00, 1'b0, {2'b11, 16'h5051});
    do_reset(1'b0, 1'b0);
    mux = 1'b1;
    rdx(8'h04, 1'b0, {2'b01, 16'h0002});
    rdx(8'h13, 1'b0, {2'b01, 16'h0013});
    for (int i = 0; i < 33; i++)
      acc(1'b0, 8'h00, 1'b0, {8'h00, 8'(i)});
    chk_tx(32, 32'h00010203);
    rdx(8'h04, 1'b0, {2'b01, 16'h000a});
    acc(1'b0, 8'h02, 1'b0, 16'h0001);
    rdx(8'h04, 1'b0, {2'b01, 16'h0002});
    rdx(8'h05, 1'b0, {2'b01, 16'h0008});
    acc(1'b0, 8'h02, 1'b0, 16'h0004);
    rdx(8'h05, 1'b0, {2'b01, 16'h0000});
    rdx(8'h00, 1'b0, {2'b01, 16'h0000});
    end_sim();
  end
endmodule
`default_nettype wire

// [dv/host_port_checker.sv]
// Pin-level checks of the host port: lanes, output enables, scan reset.
// Assumes straps stay constant between resets and are bound by name.
`timescale 1ns/10ps
`default_nettype none
module host_port_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Straps and bus
  input wire logic interface_type_select,
  input wire logic bus_width_select,
  input wire logic cs_n,
  input wire logic high_byte_enable_n,
  input wire logic low_byte_enable_n,
  input wire logic [7:0] addr,
  input wire logic data_oe_lo,
  input wire logic data_oe_hi,
  // Core and line side
  input wire logic reg_rd,
  input wire logic [7:0] tx_line_data,
  input wire logic tx_line_valid,
  input wire logic tx_line_ready,
  // Test access
  input wire logic scan_reset,
  input wire logic [2:0] test_pullup_en
);
  logic [3:0] since_rst_r;
  logic [3:0] since_rst_nxt;
  logic en_n;
  logic [1:0] exp_oe;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  always_comb begin
    since_rst_nxt = (since_rst_r == 4'hf) ? since_rst_r : since_rst_r + 4'h1;
  end
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      since_rst_r <= 4'h0;
    end else begin
      since_rst_r <= since_rst_nxt;
    end
  end
  // Lanes {hi, lo} that a 16-bit read may drive
  always_comb begin
    en_n = interface_type_select ? low_byte_enable_n : high_byte_enable_n;
    case ({en_n, addr[0]})
      2'b00: exp_oe = 2'b11;
      2'b01: exp_oe = interface_type_select ? 2'b01 : 2'b10;
      2'b10: exp_oe = interface_type_select ? 2'b10 : 2'b01;
      default: exp_oe = 2'b00;
    endcase
  end
  a_pullup_on: assert property (test_pullup_en == 3'h7)
    else $error("pull-up enables not all set");
  a_scan_rst_hold: assert property (since_rst_r < 4'h7 |-> scan_reset)
    else $error("scan reset released too early");
  a_scan_rst_end: assert property (since_rst_r > 4'h9 |-> !scan_reset)
    else $error("scan reset held too long");
  a_lane_wide: assert property (bus_width_select && !cs_n
    && (data_oe_lo || data_oe_hi) |-> {data_oe_hi, data_oe_lo} == exp_oe)
    else $error("wrong lanes driven on wide bus");
  a_lane_narrow: assert property (!bus_width_select |-> !data_oe_hi)
    else $error("upper lane driven on narrow bus");
  a_no_transfer: assert property (bus_width_select && !cs_n
    && exp_oe == 2'b00 |-> !data_oe_lo && !data_oe_hi && !reg_rd)
    else $error("transfer with both enables off");
  a_oe_needs_cs: assert property ((data_oe_lo || data_oe_hi) |->
    !$past(cs_n)) else $error("lane driven without chip select");
  a_rd_gives_oe: assert property (reg_rd |->
    ##[1:4] (data_oe_lo || data_oe_hi)) else $error("read not answered");
  a_tx_hold: assert property (tx_line_valid && !tx_line_ready |=>
    tx_line_valid && $stable(tx_line_data)) else $error("tx byte lost");
endmodule
bind host_bus_byte_lane_port host_port_checker host_port_checker_inst (
  .clk_sys(clk_sys), .sys_rst(sys_rst),
  .interface_type_select(interface_type_select),
  .bus_width_select(bus_width_select), .cs_n(cs_n),
  .high_byte_enable_n(high_byte_enable_n),
  .low_byte_enable_n(low_byte_enable_n), .addr(addr),
  .data_oe_lo(data_oe_lo), .data_oe_hi(data_oe_hi), .reg_rd(reg_rd),
  .tx_line_data(tx_line_data), .tx_line_valid(tx_line_valid),
  .tx_line_ready(tx_line_ready), .scan_reset(scan_reset),
  .test_pullup_en(test_pullup_en)
);
`default_nettype wire
